// ---- rtl/dual_timer.v ----
// cascadable pair of 8-bit timer/counters with an axi4-lite register slave
`include "dual_timer_map.vh"
module dual_timer #(
  parameter LOWF_RATIO = `LOWF_RATIO_DEFAULT
)(
  input wire CLK,
  input wire RESET_N,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  input wire LOWER_COUNT_PIN,
  input wire UPPER_COUNT_PIN,
  output reg LOWER_FF_OUT,
  output reg UPPER_FF_OUT,
  output reg IRQ
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_reg [0:1];
  reg [7:0] cmp_reg [0:1];
  reg [7:0] pwm_reg [0:1];
  reg [7:0] cnt_reg [0:1];
  reg ff_reg [0:1];
  reg [1:0] cfg_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [1:0] pin_d_reg;
  reg [11:0] pre_reg;
  reg [15:0] lowf_cnt_reg;
  reg [2:0] lowf_pre_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // ----------------------------------------------------------------
  // clock enables: high-frequency taps and low-frequency clock
  // ----------------------------------------------------------------
  wire lowf_tick = (lowf_cnt_reg == LOWF_RATIO[15:0] - 16'h0001);
  wire lowf_slow_tick = lowf_tick && (lowf_pre_reg == 3'h7);
  wire tap11 = (pre_reg[`EXP_SLOW_HF-1:0] == {`EXP_SLOW_HF{1'b1}});
  wire tap7 = (pre_reg[`EXP_DIV7-1:0] == {`EXP_DIV7{1'b1}});
  wire tap5 = (pre_reg[`EXP_DIV5-1:0] == {`EXP_DIV5{1'b1}});
  wire tap3 = (pre_reg[`EXP_DIV3-1:0] == {`EXP_DIV3{1'b1}});
  wire tap1 = pre_reg[0];
  wire slow_mode = cfg_reg[`CFG_SLOW_BIT];
  // slowest tap: hf/2^11 or lf/2^3 per tap select and power mode
  wire slowest = (cfg_reg[`CFG_TAP_BIT] || slow_mode) ? lowf_slow_tick : tap11;
  // the prescaler and lf divider free-run; a real lf crystal is modelled by a ratio
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pre_reg <= 12'h000;
      lowf_cnt_reg <= 16'h0000;
      lowf_pre_reg <= 3'h0;
    end
    else
    begin
      pre_reg <= pre_reg + 12'h001;
      lowf_cnt_reg <= lowf_tick ? 16'h0000 : lowf_cnt_reg + 16'h0001;
      if (lowf_tick)
        lowf_pre_reg <= lowf_pre_reg + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // per-timer clock select with legality gating
  // ----------------------------------------------------------------
  wire cascade = ctrl_reg[1][`CTRL_MODE_HI];
  wire [1:0] pin_fall = pin_d_reg & ~{UPPER_COUNT_PIN, LOWER_COUNT_PIN};
  wire [1:0] tick;
  wire [1:0] match;
  wire [1:0] running;
  // mode legality: illegal clock choices simply never tick
  function legal_ck;
    input [2:0] mode;
    input [2:0] ck;
    input slow;
    input is_cascade;
    begin
      legal_ck = 1'b0;
      if (is_cascade)
        legal_ck = slow ? (ck == `CK_SLOWEST || ck == `CK_PIN || ck == `CK_FULL ||
          ck == `CK_LOWF) : 1'b1;
      else if (mode == `MODE_EVENT)
        legal_ck = (ck == `CK_PIN);
      else if (mode == `MODE_PWM)
        legal_ck = slow ? (ck == `CK_SLOWEST || ck == `CK_LOWF) : (ck != `CK_PIN);
      else
        legal_ck = slow ? (ck == `CK_SLOWEST) : (ck <= `CK_DIV3);
    end
  endfunction
  function select_tick;
    input [2:0] ck;
    input s, t7, t5, t3, lf, t1, pin;
    begin
      case (ck)
        `CK_SLOWEST: select_tick = s;
        `CK_DIV7: select_tick = t7;
        `CK_DIV5: select_tick = t5;
        `CK_DIV3: select_tick = t3;
        `CK_LOWF: select_tick = lf;
        `CK_HALF: select_tick = t1;
        `CK_FULL: select_tick = 1'b1;
        default: select_tick = pin;
      endcase
    end
  endfunction
  // lower overflow feeds upper in cascade
  wire lower_wrap = tick[0] && (cnt_reg[0] == 8'hff);
  wire [15:0] cnt16 = {cnt_reg[1], cnt_reg[0]};
  wire [15:0] cmp16 = {cmp_reg[1], cmp_reg[0]};
  wire match16 = cascade && tick[0] && (cnt16 == cmp16 - 16'h0001);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      wire [2:0] mode = ctrl_reg[g][`CTRL_MODE_HI:`CTRL_MODE_LO];
      wire [2:0] ck = ctrl_reg[g][`CTRL_CK_HI:`CTRL_CK_LO];
      wire raw = select_tick(ck, slowest, tap7, tap5, tap3, lowf_tick, tap1, pin_fall[g]);
      wire ok = legal_ck(mode, ck, slow_mode, g == 0 && cascade);
      // cascade: start from upper, clock from lower select
      assign running[g] = cascade ? ctrl_reg[1][`CTRL_START_BIT] :
        ctrl_reg[g][`CTRL_START_BIT];
      if (g == 1)
      begin : up
        assign tick[g] = running[g] && (cascade ? lower_wrap : raw && ok);
      end
      else
      begin : lo
        assign tick[g] = running[g] && raw && ok;
      end
      // compare against live register, unbuffered
      assign match[g] = cascade ? match16 :
        tick[g] && (mode != `MODE_PWM) && (cnt_reg[g] + 8'h01 == cmp_reg[g]);
    end
  endgenerate
  // ----------------------------------------------------------------
  // counters and output flip-flops
  // ----------------------------------------------------------------
  integer i;
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cnt_reg[0] <= 8'h00;
      cnt_reg[1] <= 8'h00;
      ff_reg[0] <= 1'b0;
      ff_reg[1] <= 1'b0;
      pin_d_reg <= 2'b00;
    end
    else
    begin
      pin_d_reg <= {UPPER_COUNT_PIN, LOWER_COUNT_PIN};
      for (i = 0; i < 2; i = i + 1)
      begin
        if (!running[i])
        begin
          cnt_reg[i] <= 8'h00;
          ff_reg[i] <= ctrl_reg[cascade ? 1 : i][`CTRL_FF_BIT];
        end
        else if (match[i])
        begin
          cnt_reg[i] <= 8'h00;
          if (ctrl_reg[i][2:0] != `MODE_TIMER)
            ff_reg[i] <= ~ff_reg[i];
        end
        else if (tick[i])
        begin
          cnt_reg[i] <= cnt_reg[i] + 8'h01;
          if (ctrl_reg[i][2:0] == `MODE_PWM && !cascade &&
            cnt_reg[i] + 8'h01 == pwm_reg[i])
            ff_reg[i] <= ~ff_reg[i];
          if (ctrl_reg[i][2:0] == `MODE_PWM && !cascade && cnt_reg[i] == 8'hff)
            ff_reg[i] <= ~ff_reg[i];
        end
      end
    end
  end
  // pwm overflow also raises the match interrupt
  wire [1:0] pwm_wrap;
  assign pwm_wrap[0] = !cascade && tick[0] && ctrl_reg[0][2:0] == `MODE_PWM &&
    cnt_reg[0] == 8'hff;
  assign pwm_wrap[1] = !cascade && tick[1] && ctrl_reg[1][2:0] == `MODE_PWM &&
    cnt_reg[1] == 8'hff;
  // in cascade only the upper interrupt fires
  wire [1:0] event_set = cascade ? {match16, 1'b0} : (match | pwm_wrap);
  // ----------------------------------------------------------------
  // axi4-lite slave: address and data in either order, one write at a time
  // ----------------------------------------------------------------
  wire do_write = aw_got_reg && w_got_reg && !BVALID;
  wire [31:0] wd = w_data_reg;
  wire wl = w_strb_reg[0];
  reg [31:0] rd_next;
  always @*
  begin
    rd_next = 32'h00000000;
    case (ARADDR)
      `OFS_LOWER_CTRL: rd_next = {24'h0, ctrl_reg[0]};
      `OFS_UPPER_CTRL: rd_next = {24'h0, ctrl_reg[1]};
      `OFS_LOWER_CMP: rd_next = {24'h0, cmp_reg[0]};
      `OFS_UPPER_CMP: rd_next = {24'h0, cmp_reg[1]};
      `OFS_LOWER_PWM: rd_next = {24'h0, pwm_reg[0]};
      `OFS_UPPER_PWM: rd_next = {24'h0, pwm_reg[1]};
      `OFS_COUNT: rd_next = {16'h0, cnt16};
      `OFS_SYS_CFG: rd_next = {30'h0, cfg_reg};
      `OFS_IRQ_STATUS: rd_next = {30'h0, status_reg};
      `OFS_IRQ_MASK: rd_next = {30'h0, mask_reg};
      default: rd_next = 32'h00000000;
    endcase
  end
  wire rd_hit = (ARADDR <= `OFS_IRQ_MASK) && (ARADDR[1:0] == 2'b00);
  wire wr_hit = (aw_addr_reg <= `OFS_IRQ_MASK) && (aw_addr_reg[1:0] == 2'b00);
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RRESP <= 2'b00;
      RDATA <= 32'h00000000;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      ctrl_reg[0] <= `CTRL_RESET;
      ctrl_reg[1] <= `CTRL_RESET;
      cmp_reg[0] <= `CMP_RESET;
      cmp_reg[1] <= `CMP_RESET;
      pwm_reg[0] <= `CMP_RESET;
      pwm_reg[1] <= `CMP_RESET;
      cfg_reg <= 2'b00;
      status_reg <= 2'b00;
      mask_reg <= 2'b00;
      LOWER_FF_OUT <= 1'b1;
      UPPER_FF_OUT <= 1'b1;
      IRQ <= 1'b0;
    end
    else
    begin
      AWREADY <= !aw_got_reg && !AWREADY && AWVALID;
      WREADY <= !w_got_reg && !WREADY && WVALID;
      if (AWVALID && AWREADY)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
      end
      if (BVALID && BREADY)
        BVALID <= 1'b0;
      // status: hardware set wins over software clear
      status_reg <= event_set | status_reg;
      if (do_write)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_hit ? 2'b00 : 2'b10;
        if (wl)
        begin
          case (aw_addr_reg)
            `OFS_LOWER_CTRL: ctrl_reg[0] <= wd[7:0];
            `OFS_UPPER_CTRL: ctrl_reg[1] <= wd[7:0];
            `OFS_LOWER_CMP: cmp_reg[0] <= wd[7:0];
            `OFS_UPPER_CMP: cmp_reg[1] <= wd[7:0];
            `OFS_LOWER_PWM: pwm_reg[0] <= wd[7:0];
            `OFS_UPPER_PWM: pwm_reg[1] <= wd[7:0];
            `OFS_SYS_CFG: cfg_reg <= wd[1:0];
            `OFS_IRQ_STATUS: status_reg <= event_set | (status_reg & ~wd[1:0]);
            `OFS_IRQ_MASK: mask_reg <= wd[1:0];
            default: ;
          endcase
        end
      end
      // read: one cycle address accept, data next cycle
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RDATA <= rd_next;
        RRESP <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
      // pins show the inverse of the flip-flops
      LOWER_FF_OUT <= ~ff_reg[0];
      UPPER_FF_OUT <= ~ff_reg[1];
      IRQ <= |((event_set | status_reg) & mask_reg);
    end
  end
endmodule // dual_timer

// ---- rtl/dual_timer_map.vh ----
// register offsets, field positions, reset values and clock codes for the dual 8-bit timer
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH
// ----------------------------------------------------------------
// register byte offsets (axi4-lite, one aligned word each)
// ----------------------------------------------------------------
`define OFS_LOWER_CTRL 8'h00
`define OFS_UPPER_CTRL 8'h04
`define OFS_LOWER_CMP 8'h08
`define OFS_UPPER_CMP 8'h0c
`define OFS_LOWER_PWM 8'h10
`define OFS_UPPER_PWM 8'h14
`define OFS_COUNT 8'h18
`define OFS_SYS_CFG 8'h1c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
// ----------------------------------------------------------------
// control register fields: [7] flip-flop init, [6:4] clock, [3] start, [2:0] mode
// ----------------------------------------------------------------
`define CTRL_FF_BIT 7
`define CTRL_CK_HI 6
`define CTRL_CK_LO 4
`define CTRL_START_BIT 3
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 0
`define CTRL_RESET 8'h00
`define CMP_RESET 8'h00
// sys_cfg: [0] divider tap select, [1] slow/sleep power mode
`define CFG_TAP_BIT 0
`define CFG_SLOW_BIT 1
// ----------------------------------------------------------------
// mode codes and clock select codes
// ----------------------------------------------------------------
`define MODE_TIMER 3'h0
`define MODE_EVENT 3'h1
`define MODE_PDO 3'h2
`define MODE_PWM 3'h3
`define MODE_16_FLAG_BIT 2
`define CK_SLOWEST 3'h0
`define CK_DIV7 3'h1
`define CK_DIV5 3'h2
`define CK_DIV3 3'h3
`define CK_LOWF 3'h4
`define CK_HALF 3'h5
`define CK_FULL 3'h6
`define CK_PIN 3'h7
// ----------------------------------------------------------------
// prescaler exponents and default low-frequency ratio
// ----------------------------------------------------------------
`define EXP_SLOW_HF 11
`define EXP_DIV7 7
`define EXP_DIV5 5
`define EXP_DIV3 3
`define EXP_SLOW_LF 3
`define LOWF_RATIO_DEFAULT 305
`endif

// ---- tb/dual_timer_asserts.sv ----
// bus handshake and interrupt checker for the dual timer
module dual_timer_asserts (
  input wire CLK,
  input wire RESET_N,
  input wire AWREADY,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  input wire IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------------------------------
  // handshake steps
  // ----------------------------------------------------------------
  sequence s_wr_taken;
    AWREADY && WREADY;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_aw_pulse; AWREADY |=> !AWREADY; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
  property p_w_pulse; WREADY |=> !WREADY; endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("wready held");
  // walk puts the response two cycles after both halves are taken
  property p_b_after; s_wr_taken |-> ##[1:3] BVALID; endproperty
  a_b_after: assert property (p_b_after) else $error("no write response");
  property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_code; BVALID |-> BRESP == 2'b00 || BRESP == 2'b10; endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response code");
  property p_r_after; s_rd_taken |=> RVALID; endproperty
  a_r_after: assert property (p_r_after) else $error("no read data");
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_upper; RVALID |-> RDATA[31:16] == 16'h0000; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  // stopped counters after reset cannot have raised anything yet
  property p_irq_quiet; $rose(RESET_N) |-> !IRQ; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq after reset");
endmodule // dual_timer_asserts

bind dual_timer dual_timer_asserts u_chk (.CLK, .RESET_N, .AWREADY, .WREADY, .BVALID,
  .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .IRQ);

// ---- tb/dual_timer_tb.sv ----
// self-checking bench for the cascadable dual timer
`include "dual_timer_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module dual_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RESET_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic LOWER_COUNT_PIN = 1, UPPER_COUNT_PIN = 1;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0] WSTRB = 0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, LOWER_FF_OUT, UPPER_FF_OUT, IRQ;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  int fails = 0, n_checks = 0, cyc = 0, n;
  logic [31:0] d;
  logic [1:0] r;
  int ck_t[3] = '{3, 0, 0};
  int cfg_t[3] = '{2, 2, 1};
  // short low-freq ratio keeps the slow taps at 32 cycles a tick
  dual_timer #(.LOWF_RATIO(4)) u_dut (.CLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .LOWER_COUNT_PIN, .UPPER_COUNT_PIN, .LOWER_FF_OUT,
    .UPPER_FF_OUT, .IRQ);
  always #50 CLK = ~CLK;
  // hang guard, about five times the expected run
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge CLK);
      if (AWREADY) aw = 1'b1;
      if (WREADY) w = 1'b1;
      AWVALID <= !aw;
      WVALID <= !w;
    end
    while (!BVALID) @(posedge CLK);
    rs = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    while (!RVALID) @(posedge CLK);
    v = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic w1(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    `CHK("bresp", 2'b00, r)
  endtask
  function automatic logic [31:0] ctl(input int ck, input logic st, input int m);
    ctl = {24'h0, 1'b0, 3'(ck), st, 3'(m)};
  endfunction
  // stopped set-up first, then the same byte with start set
  task automatic go(input logic [7:0] a, input int ck, input int m);
    w1(a, ctl(ck, 1'b0, m));
    w1(a, ctl(ck, 1'b1, m));
  endtask
  // stop with every other field left alone, then clear flags
  task automatic halt(input logic [7:0] a, input int ck, input int m);
    w1(a, ctl(ck, 1'b0, m));
    w1(`OFS_IRQ_STATUS, 32'h3);
  endtask
  task automatic wait_irq(input int lim, output int c);
    c = 0;
    while (IRQ !== 1'b1 && c < lim)
    begin
      @(posedge CLK);
      c++;
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(`OFS_UPPER_CTRL, d, r);
    `CHK("ctrl_reset", 32'h0, d)
    wr(8'h30, 32'h1, r);
    `CHK("bresp_unmapped", 2'b10, r)
    rd(8'h30, d, r);
    `CHK("rresp_unmapped", 2'b10, r)
    `CHK("rdata_unmapped", 32'h0, d)
    w1(`OFS_IRQ_MASK, 32'h3);
    w1(`OFS_LOWER_CMP, 32'h5);
    w1(`OFS_LOWER_CTRL, ctl(3, 1'b0, 0));
    repeat (100) @(posedge CLK);
    rd(`OFS_COUNT, d, r);
    `CHK("held_zero", 8'h00, d[7:0])
    `CHK("irq_idle", 1'b0, IRQ)
    $display("test reset and stop done");
    w1(`OFS_LOWER_CTRL, ctl(3, 1'b1, 0));
    wait_irq(60, n);
    `CHK("match_time", 1'b1, n >= 28 && n <= 44)
    rd(`OFS_IRQ_STATUS, d, r);
    `CHK("status_lower", 32'h1, d)
    w1(`OFS_IRQ_MASK, 32'h0);
    w1(`OFS_IRQ_STATUS, 32'h3);
    repeat (60) @(posedge CLK);
    `CHK("irq_masked", 1'b0, IRQ)
    rd(`OFS_COUNT, d, r);
    `CHK("below_cmp", 1'b1, d[7:0] < 8'h05)
    w1(`OFS_IRQ_MASK, 32'h3);
    wait_irq(10, n);
    `CHK("resumed", 1'b1, IRQ)
    halt(`OFS_LOWER_CTRL, 3, 0);
    $display("test timer match done");
    w1(`OFS_LOWER_CMP, 32'hc8);
    go(`OFS_LOWER_CTRL, 3, 0);
    repeat (80) @(posedge CLK);
    w1(`OFS_LOWER_CMP, 32'h14);
    wait_irq(400, n);
    `CHK("cmp_immediate", 1'b1, n < 100)
    halt(`OFS_LOWER_CTRL, 3, 0);
    w1(`OFS_LOWER_CMP, 32'hff);
    for (int i = 1; i < 8; i++)
    begin
      go(`OFS_LOWER_CTRL, i, 0);
      repeat (300) @(posedge CLK);
      rd(`OFS_COUNT, d, r);
      `CHK("clock_legal", i <= 3, d[7:0] != 8'h00)
      halt(`OFS_LOWER_CTRL, i, 0);
    end
    go(`OFS_LOWER_CTRL, 7, 1);
    repeat (3)
    begin
      repeat (4) @(posedge CLK);
      LOWER_COUNT_PIN <= 1'b0;
      repeat (4) @(posedge CLK);
      LOWER_COUNT_PIN <= 1'b1;
    end
    repeat (4) @(posedge CLK);
    rd(`OFS_COUNT, d, r);
    `CHK("pin_events", 8'h03, d[7:0])
    halt(`OFS_LOWER_CTRL, 7, 1);
    $display("test clock legality done");
    for (int i = 0; i < 3; i++)
    begin
      w1(`OFS_SYS_CFG, 32'(cfg_t[i]));
      go(`OFS_LOWER_CTRL, ck_t[i], 0);
      repeat (200) @(posedge CLK);
      rd(`OFS_COUNT, d, r);
      `CHK("slow_tap", ck_t[i] == 0, d[7:0] >= 8'h05 && d[7:0] <= 8'h07)
      halt(`OFS_LOWER_CTRL, ck_t[i], 0);
    end
    $display("test slow taps done");
    w1(`OFS_SYS_CFG, 32'h0);
    w1(`OFS_LOWER_PWM, 32'h02);
    w1(`OFS_UPPER_PWM, 32'h00);
    rd(`OFS_LOWER_PWM, d, r);
    `CHK("pwm_reg", 32'h02, d)
    go(`OFS_LOWER_CTRL, 6, 3);
    repeat (10) @(posedge CLK);
    // one full 256-count period: pin low while count is 2..255
    n = 0;
    repeat (256)
    begin
      @(posedge CLK);
      if (LOWER_FF_OUT === 1'b0) n++;
    end
    `CHK("pwm_duty", 254, n)
    halt(`OFS_LOWER_CTRL, 6, 3);
    `CHK("ff_idle", 2'b11, {UPPER_FF_OUT, LOWER_FF_OUT})
    $display("test pwm done");
    w1(`OFS_LOWER_CMP, 32'h02);
    w1(`OFS_UPPER_CMP, 32'h01);
    w1(`OFS_LOWER_CTRL, ctl(3, 1'b0, 3));
    go(`OFS_UPPER_CTRL, 7, 4);
    wait_irq(2300, n);
    `CHK("cascade_time", 1'b1, n >= 2040 && n <= 2075)
    rd(`OFS_IRQ_STATUS, d, r);
    `CHK("cascade_flag", 32'h2, d)
    halt(`OFS_UPPER_CTRL, 7, 4);
    $display("test cascade done");
    results();
  end
endmodule // dual_timer_tb
